// >>> src/afr_group_ctrl.sv
// Pair, quad and all-eight resync levels decoded from the group register.
// Assumes the group register value is stable on pclk.
`timescale 1ns/1ns

module afr_group_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] group_reg,
  output afr_pkg::afr_group_t group_resync
);

  afr_pkg::afr_group_t s_reg;
  afr_pkg::afr_group_t s_next;

  // Field split; bit 7 carries nothing
  always_comb begin
    s_next = s_reg;
    s_next.pair = group_reg[afr_pkg::GRP_PAIR_MSB:afr_pkg::GRP_PAIR_LSB];
    s_next.quad_second = group_reg[afr_pkg::GRP_QUAD_SECOND];
    s_next.quad_first = group_reg[afr_pkg::GRP_QUAD_FIRST];
    s_next.all8 = group_reg[afr_pkg::GRP_ALL];
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign group_resync = s_reg;

endmodule

// >>> src/afr_lane_ctrl.sv
// One channel's resync control: resync level and read pointer centering.
// Assumes align_off comes from outside pclk and must be synchronised here.
`timescale 1ns/1ns

module afr_lane_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic resync_bit,
  input wire logic align_off,
  output logic fifo_resync,
  output logic rd_ptr_center
);

  typedef struct packed {
    logic [1:0] sync;
    logic resync;
    logic center;
  } afr_lane_state_t;

  afr_lane_state_t s_reg;
  afr_lane_state_t s_next;

  // Next state; sync[0] feeds only sync[1]
  always_comb begin
    s_next = s_reg;
    s_next.sync = {s_reg.sync[0], align_off};
    s_next.resync = resync_bit;
    s_next.center = resync_bit & s_reg.sync[1];
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign fifo_resync = s_reg.resync;
  assign rd_ptr_center = s_reg.center;

endmodule

// >>> src/afr_pkg.sv
// Constants and types shared by the alignment FIFO resync control block.
// Assumes one APB clock domain; register indices become byte addresses times four.
package afr_pkg;

  // Printed register indices (not word aligned, so the byte address is four times the index)
  localparam logic [19:0] IDX_CHAN = 20'h30017;
  localparam logic [19:0] IDX_GROUP = 20'h30018;
  localparam logic [19:0] ADDR_CHAN = IDX_CHAN << 2;
  localparam logic [19:0] ADDR_GROUP = IDX_GROUP << 2;

  // Reset values
  localparam logic [7:0] CHAN_RST = 8'h00;
  localparam logic [7:0] GROUP_RST = 8'h00;

  // Per-channel register bit positions
  localparam int CHAN_LANE_B4 = 0;
  localparam int CHAN_LANE_B3 = 1;
  localparam int CHAN_LANE_B2 = 2;
  localparam int CHAN_LANE_B1 = 3;
  localparam int CHAN_LANE_A4 = 4;
  localparam int CHAN_LANE_A3 = 5;
  localparam int CHAN_LANE_A2 = 6;
  localparam int CHAN_LANE_A1 = 7;

  // Group register fields
  localparam int GRP_PAIR_LSB = 0;
  localparam int GRP_PAIR_MSB = 3;
  localparam int GRP_QUAD_SECOND = 4;
  localparam int GRP_QUAD_FIRST = 5;
  localparam int GRP_ALL = 6;
  localparam logic [7:0] GRP_USED_MASK = 8'h7F;

  // Bus answer phase
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_DONE = 1'b1
  } afr_bus_st_t;

  // Register selected by an address
  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_CHAN = 2'b01,
    SEL_GROUP = 2'b10
  } afr_sel_t;

  // Group resync outputs travel together
  typedef struct packed {
    logic [3:0] pair;
    logic quad_first;
    logic quad_second;
    logic all8;
  } afr_group_t;

endpackage

// >>> src/afr_top.sv
// Alignment FIFO resync control: APB slave with per-channel and group resync registers.
// Assumes an APB master on pclk; the FIFO datapath sits outside and obeys the resync levels.
`timescale 1ns/1ns

// How it works
// - The per-channel register has one bit per lane, b4 at bit 0 up to a1 at bit 7.
// - Setting a lane's bit resyncs that lane's FIFO alone.
// - With alignment off for a lane, its resync also centres the FIFO read pointer.
// - Resync bits are plain read-write levels that software must clear again.
// - Group bits 0 to 3 resync the joint FIFO of each two-lane pair.
// - Group bit 4 resyncs the second quad and bit 5 the first quad.
// - Group bit 6 resyncs the eight-lane FIFO and bit 7 is unused.
module afr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] lane_align_off,
  output logic [7:0] lane_fifo_resync,
  output logic [7:0] lane_rd_ptr_center,
  output afr_pkg::afr_group_t group_resync
);

  typedef struct packed {
    afr_pkg::afr_bus_st_t bus;
    logic [7:0] chan;
    logic [7:0] group;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } afr_top_state_t;

  afr_top_state_t s_reg;
  afr_top_state_t s_next;

  // Address decode, shared by the read and write paths
  function automatic afr_pkg::afr_sel_t reg_sel(input logic [19:0] addr);
    if (addr == afr_pkg::ADDR_CHAN) begin
      reg_sel = afr_pkg::SEL_CHAN;
    end else if (addr == afr_pkg::ADDR_GROUP) begin
      reg_sel = afr_pkg::SEL_GROUP;
    end else begin
      reg_sel = afr_pkg::SEL_NONE;
    end
  endfunction

  // APB slave: one wait state so that read data and pready leave flip-flops
  always_comb begin
    s_next = s_reg;
    s_next.ready = 1'b0;
    s_next.err = 1'b0;
    case (s_reg.bus)
      afr_pkg::BUS_IDLE: begin
        if (psel && penable) begin
          s_next.bus = afr_pkg::BUS_DONE;
          s_next.ready = 1'b1;
          s_next.rdata = 32'h0000_0000;
          if (reg_sel(paddr) == afr_pkg::SEL_CHAN) begin
            s_next.rdata = {24'h00_0000, s_reg.chan};
          end else if (reg_sel(paddr) == afr_pkg::SEL_GROUP) begin
            s_next.rdata = {24'h00_0000, s_reg.group};
          end else begin
            s_next.err = 1'b1; // Unmapped address
          end
        end
      end
      afr_pkg::BUS_DONE: begin
        // Write lands at the edge where pready is sampled high
        s_next.bus = afr_pkg::BUS_IDLE;
        if (psel && penable && pwrite) begin
          if (reg_sel(paddr) == afr_pkg::SEL_CHAN) begin
            s_next.chan = pwdata[7:0];
          end else if (reg_sel(paddr) == afr_pkg::SEL_GROUP) begin
            s_next.group = pwdata[7:0] & afr_pkg::GRP_USED_MASK;
          end
        end
      end
      default: begin
        s_next.bus = afr_pkg::BUS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg.bus <= afr_pkg::BUS_IDLE;
      s_reg.chan <= afr_pkg::CHAN_RST;
      s_reg.group <= afr_pkg::GROUP_RST;
      s_reg.rdata <= 32'h0000_0000;
      s_reg.ready <= 1'b0;
      s_reg.err <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;

  // One control per lane; the held bit keeps the FIFO in resync
  generate
    for (genvar i = 0; i < 8; i++) begin : g_lane
      afr_lane_ctrl u_lane (
        .pclk(pclk),
        .presetn(presetn),
        .resync_bit(s_reg.chan[i]),
        .align_off(lane_align_off[i]),
        .fifo_resync(lane_fifo_resync[i]),
        .rd_ptr_center(lane_rd_ptr_center[i])
      );
    end
  endgenerate

  // Pair, quad and all-eight levels
  afr_group_ctrl u_group (
    .pclk(pclk),
    .presetn(presetn),
    .group_reg(s_reg.group),
    .group_resync(group_resync)
  );

endmodule

// >>> verif/afr_chk.sv
// Port checker for the resync control block.
// Assumes the one-wait-state APB answer of afr_top.
`timescale 1ns/1ns
module afr_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [19:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] lane_align_off,
  input wire logic [7:0] lane_fifo_resync,
  input wire logic [7:0] lane_rd_ptr_center,
  input wire afr_pkg::afr_group_t group_resync
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wa;
  logic [7:0] wd1, wd2;
  // Completed write and its data two edges back, when outputs follow
  assign wa = psel && penable && pready && pwrite;
  always_ff @(posedge pclk) begin
    wd1 <= pwdata[7:0];
    wd2 <= wd1;
  end
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  a_chan_write: assert property (wa && paddr == afr_pkg::ADDR_CHAN
    |-> ##2 lane_fifo_resync == wd2) else $error("lane resync differs from write");
  a_group_write: assert property (wa && paddr == afr_pkg::ADDR_GROUP
    |-> ##2 group_resync == {wd2[3:0], wd2[5], wd2[4], wd2[6]}) else $error("group resync differs");
  // Sampled presetn skips the edge where a reset that began one edge earlier has just cleared the levels
  a_level_hold: assert property (presetn && !$past(wa, 2)
    |-> $stable(lane_fifo_resync) && $stable(group_resync)) else $error("resync level moved");
  a_ready_wait: assert property ($rose(penable) && psel
    |-> s_wait ##1 pready) else $error("ready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_map: assert property (pready
    |-> pslverr == (paddr != afr_pkg::ADDR_CHAN && paddr != afr_pkg::ADDR_GROUP)) else $error("bad error flag");
  a_center_map: assert property ($stable(lane_align_off) [*4]
    |-> lane_rd_ptr_center == (lane_fifo_resync & lane_align_off)) else $error("centre mismatch");
  a_reset_zero: assert property ($rose(presetn)
    |-> lane_fifo_resync == 8'h00 && group_resync == 7'h00 && !pready) else $error("not zero after reset");
endmodule

bind afr_top afr_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .lane_align_off, .lane_fifo_resync, .lane_rd_ptr_center, .group_resync);

// >>> verif/afr_top_bench.sv
// Bench for the resync control block: APB calls with expected values.
// Assumes an APB slave that may add wait states and a 2-FF sync on the align-off inputs.
`timescale 1ns/1ns
module afr_top_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] align_off, fifo_rs, ctr;
  afr_pkg::afr_group_t grp;
  int err_total, n_tests;
  afr_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .lane_align_off(align_off), .lane_fifo_resync(fifo_rs), .lane_rd_ptr_center(ctr), .group_resync(grp));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One compare per kind of result: read data, error flag, lane levels, group levels
  task chk_rd(input logic [31:0] e);
    chk(rd, e);
  endtask
  task chk_err(input logic e);
    chk({31'h0, er}, {31'h0, e});
  endtask
  task chk_lane(input logic [7:0] g, input logic [7:0] e);
    chk({24'h0, g}, {24'h0, e});
  endtask
  task chk_grp(input logic [7:0] e);
    chk({25'h0, grp}, gexp(e));
  endtask
  // Request held until pready is seen high at a rising edge; the answer is taken at that edge
  task xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle cycle, so the next setup never drives psel twice in one time step
    @(posedge pclk);
  endtask
  function automatic logic [31:0] gexp(input logic [7:0] d);
    return {25'h0, d[3:0], d[5], d[4], d[6]};
  endfunction
  task give_verdict();
    $display("errors=%0d checks=%0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    align_off = 8'hA5;
    err_total = 0;
    n_tests = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, afr_pkg::ADDR_CHAN, 32'h0);
    chk_rd(32'h0);
    xfer(1'b0, afr_pkg::ADDR_GROUP, 32'h0);
    chk_rd(32'h0);
    // Walking one through every lane and group bit, bit 7 of group included
    for (int i = 0; i < 8; i++) begin
      xfer(1'b1, afr_pkg::ADDR_CHAN, 32'h1 << i);
      @(posedge pclk);
      chk_lane(fifo_rs, 8'(32'h1 << i));
      chk_lane(ctr, 8'(32'h1 << i) & 8'hA5);
      xfer(1'b0, afr_pkg::ADDR_CHAN, 32'h0);
      chk_rd(32'h1 << i);
      chk_err(1'b0);
      xfer(1'b1, afr_pkg::ADDR_GROUP, 32'h1 << i);
      @(posedge pclk);
      chk_grp(8'(32'h1 << i));
      xfer(1'b0, afr_pkg::ADDR_GROUP, 32'h0);
      chk_rd((32'h1 << i) & 32'h7F);
    end
    // Clearing the lane bits ends resync; an unmapped write is refused and changes nothing
    xfer(1'b1, afr_pkg::ADDR_CHAN, 32'h0);
    xfer(1'b1, 20'h00000, 32'hFF);
    chk_err(1'b1);
    @(posedge pclk);
    chk_lane(fifo_rs, 8'h00);
    chk_grp(8'h80);
    // New align-off pattern; centring follows it once it has crossed the synchroniser
    align_off <= 8'h5A;
    xfer(1'b1, afr_pkg::ADDR_CHAN, 32'hFF);
    @(posedge pclk);
    chk_lane(fifo_rs, 8'hFF);
    chk_lane(ctr, 8'h5A);
    xfer(1'b1, afr_pkg::ADDR_GROUP, 32'h7F);
    @(posedge pclk);
    chk_grp(8'h7F);
    // Mid-run reset: every level and both registers return to zero
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_grp(8'h00);
    chk_lane(fifo_rs, 8'h00);
    chk_lane(ctr, 8'h00);
    xfer(1'b0, afr_pkg::ADDR_CHAN, 32'h0);
    chk_rd(32'h0);
    xfer(1'b0, afr_pkg::ADDR_GROUP, 32'h0);
    chk_rd(32'h0);
    give_verdict();
  end
  // Whole run is under two hundred cycles
  initial begin
    repeat (3000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
endmodule
